// ### shared/qcn_pkg.sv
// Constants for the quadrant clock network control block.
// Assumes every clock source is a sampled waveform, synchronous to the system clock.
package qcn_pkg;

  // Primary network dimensions
  localparam int QCN_QUADS       = 4;
  localparam int QCN_LANES       = 16;
  localparam int QCN_SOURCES     = 64;
  localparam int QCN_MID_SWITCHES = 4;
  localparam int QCN_MID_WIDTH   = QCN_SOURCES / QCN_MID_SWITCHES;
  localparam int QCN_QUAD_CLOCKS = QCN_QUADS * QCN_LANES;

  // Selector count and inputs per selector
  localparam int QCN_SELECTORS   = 2;
  localparam int QCN_SEL_INPUTS  = 2;

  // Candidate index width and special indices
  localparam int        QCN_IDX_W      = 7;
  localparam logic [6:0] QCN_IDX_FABRIC = 7'h40;
  localparam logic [6:0] QCN_IDX_SEL0   = 7'h40;
  localparam logic [6:0] QCN_IDX_LAST   = 7'h41;
  localparam int        QCN_CAND_W     = 66;

  // Edge clock networks: left and right sides only
  localparam int QCN_SIDES         = 2;
  localparam int QCN_BANKS_PER_SIDE = 2;
  localparam int QCN_NETS_PER_BANK = 2;
  localparam int QCN_EDGE_NETS     = QCN_SIDES * QCN_BANKS_PER_SIDE * QCN_NETS_PER_BANK;
  localparam int QCN_EDGE_SEL_W    = 3;

  // Edge source encodings
  localparam logic [2:0] QCN_EDGE_PIN     = 3'h0;
  localparam logic [2:0] QCN_EDGE_DELAY90 = 3'h1;
  localparam logic [2:0] QCN_EDGE_SYNTH_P = 3'h2;
  localparam logic [2:0] QCN_EDGE_SYNTH_S = 3'h3;
  localparam logic [2:0] QCN_EDGE_BRIDGE  = 3'h4;
  localparam logic [2:0] QCN_EDGE_INT     = 3'h5;

  // Reset value of every clock output and gate state
  localparam logic QCN_RST_LEVEL = 1'b0;

  typedef enum logic {SEL_RUN, SEL_HOLD} qcn_sel_state_t;

endpackage

// ### rtl/qcn_clock_network.sv
// Quadrant clock network: mid switches, gates, selectors, center switch, edge clocks.
// Assumes all clocks are sampled waveforms synchronous to clock; fabric drives controls.
//
// Behaviour
// - Four quadrants, each carrying sixteen clocks into its region.
// - Up to sixty-four distinct clock sources enter the primary network.
// - Sources pass four mid switches, then a center switch feeding quadrants.
// - A disabled gate holds its clock at a static low level.
// - Gating never makes glitches or runt pulses; the gated register adds one cycle of latency.
// - Gates act on mid switch outputs, ahead of the center switch.
// - Selector switches between two clocks, glitch-free or plain, per its mode.
// - Two selectors, each output reachable from all four quadrants.
// - Selector candidates are every mid switch output plus the fabric clock.
// - Each selector output enters one center switch input.
// - Two edge clock nets per bank, left and right sides only.
// - Edge clock from pin, 90 degree delay line, synthesizer, bridge or internal.
`timescale 1ns/1ns

module qcn_clock_network
  import qcn_pkg::*;
(
  // System
  input  wire logic                                   clock,
  input  wire logic                                   srst,
  // Primary sources and fabric clock
  input  wire logic [QCN_SOURCES-1:0]                 clk_src,
  input  wire logic                                   fabric_clk,
  // Gate enables, one per mid switch output
  input  wire logic [QCN_SOURCES-1:0]                 gate_en,
  // Selector controls
  input  wire logic [QCN_SELECTORS*QCN_SEL_INPUTS*QCN_IDX_W-1:0] sel_cand,
  input  wire logic [QCN_SELECTORS-1:0]               sel_choose,
  input  wire logic [QCN_SELECTORS-1:0]               sel_glitchless,
  // Center switch lane selects
  input  wire logic [QCN_QUAD_CLOCKS*QCN_IDX_W-1:0]   center_sel,
  // Edge clock sources and selects
  input  wire logic [QCN_EDGE_NETS-1:0]               edge_pin,
  input  wire logic [QCN_EDGE_NETS-1:0]               delay_line_output,
  input  wire logic [QCN_EDGE_NETS-1:0]               synth_primary_output,
  input  wire logic [QCN_EDGE_NETS-1:0]               synth_secondary_output,
  input  wire logic [QCN_EDGE_NETS-1:0]               edge_clock_bridge,
  input  wire logic [QCN_EDGE_NETS-1:0]               edge_internal,
  input  wire logic [QCN_EDGE_NETS*QCN_EDGE_SEL_W-1:0] edge_sel,
  // Outputs
  output logic      [QCN_QUAD_CLOCKS-1:0]             quad_clk,
  output logic      [QCN_SELECTORS-1:0]               sel_clk,
  output logic      [QCN_SOURCES-1:0]                 gate_on,
  output logic      [QCN_EDGE_NETS-1:0]               edge_clock_net
);

  function automatic logic pick_bit(input logic [QCN_CAND_W-1:0] v,
                                    input logic [QCN_IDX_W-1:0]  idx);
    pick_bit = (idx <= QCN_IDX_LAST) ? v[idx] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mid switches: four groups of sixteen sources
  logic [QCN_SOURCES-1:0] mid_out;
  always_comb begin
    for (int m = 0; m < QCN_MID_SWITCHES; m++) begin
      for (int l = 0; l < QCN_MID_WIDTH; l++) begin
        mid_out[m*QCN_MID_WIDTH+l] = clk_src[m*QCN_MID_WIDTH+l];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quadrant clock gates on mid outputs
  logic [QCN_SOURCES-1:0] en_meta;
  logic [QCN_SOURCES-1:0] en_sync;
  logic [QCN_SOURCES-1:0] gated;
  logic [QCN_SOURCES-1:0] next_gate_on;
  logic [QCN_SOURCES-1:0] next_gated;

  always_comb begin
    for (int i = 0; i < QCN_SOURCES; i++) begin
      // Only move the gate in a low phase, so a high pulse is never cut short
      next_gate_on[i] = mid_out[i] ? gate_on[i] : en_sync[i];
      next_gated[i]   = mid_out[i] & next_gate_on[i];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      en_meta <= '0;
      en_sync <= '0;
      gate_on <= '0;
      gated   <= '0;
    end else begin
      en_meta <= gate_en;
      en_sync <= en_meta;
      gate_on <= next_gate_on;
      gated   <= next_gated;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dynamic clock selectors
  logic [QCN_CAND_W-1:0]              sel_pool;
  logic [QCN_SELECTORS-1:0]           sel_cur;
  logic [QCN_SELECTORS-1:0]           next_sel_cur;
  logic [QCN_SELECTORS-1:0]           next_sel_clk;
  logic [QCN_SELECTORS-1:0]           sel_in_old;
  logic [QCN_SELECTORS-1:0]           sel_in_new;
  logic [QCN_SELECTORS-1:0]           sel_in_pick;
  qcn_sel_state_t                     sel_state [QCN_SELECTORS];
  qcn_sel_state_t                     next_sel_state [QCN_SELECTORS];

  always_comb begin
    sel_pool = {1'b0, fabric_clk, mid_out};
    for (int s = 0; s < QCN_SELECTORS; s++) begin
      sel_in_old[s]  = pick_bit(sel_pool,
                         sel_cand[(s*QCN_SEL_INPUTS+sel_cur[s])*QCN_IDX_W +: QCN_IDX_W]);
      sel_in_new[s]  = pick_bit(sel_pool,
                         sel_cand[(s*QCN_SEL_INPUTS+sel_choose[s])*QCN_IDX_W +: QCN_IDX_W]);
      sel_in_pick[s] = sel_in_new[s];
      next_sel_cur[s]   = sel_cur[s];
      next_sel_state[s] = sel_state[s];
      next_sel_clk[s]   = sel_in_old[s];
      if (!sel_glitchless[s]) begin
        // Plain multiplexer: follows select at once, stopped inputs allowed
        next_sel_cur[s]   = sel_choose[s];
        next_sel_state[s] = SEL_RUN;
        next_sel_clk[s]   = sel_in_pick[s];
      end else begin
        case (sel_state[s])
          SEL_RUN: begin
            if (sel_choose[s] != sel_cur[s] && !sel_in_old[s]) begin
              next_sel_state[s] = SEL_HOLD;
              next_sel_clk[s]   = 1'b0;
            end
          end
          SEL_HOLD: begin
            next_sel_clk[s] = 1'b0;
            // Needs the new clock running; a stopped high input stalls here
            if (!sel_in_new[s]) begin
              next_sel_cur[s]   = sel_choose[s];
              next_sel_state[s] = SEL_RUN;
            end
          end
          default: begin
            next_sel_state[s] = SEL_RUN;
            next_sel_clk[s]   = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sel_cur <= '0;
      sel_clk <= '0;
      for (int s = 0; s < QCN_SELECTORS; s++) begin
        sel_state[s] <= SEL_RUN;
      end
    end else begin
      sel_cur <= next_sel_cur;
      sel_clk <= next_sel_clk;
      for (int s = 0; s < QCN_SELECTORS; s++) begin
        sel_state[s] <= next_sel_state[s];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Center switch: gated mids plus both selectors, to every quadrant lane
  logic [QCN_CAND_W-1:0]      center_pool;
  logic [QCN_QUAD_CLOCKS-1:0] next_quad_clk;

  always_comb begin
    // Gated and selector paths both carry one register, so latency matches
    center_pool = {sel_clk, gated};
    for (int q = 0; q < QCN_QUAD_CLOCKS; q++) begin
      next_quad_clk[q] = pick_bit(center_pool, center_sel[q*QCN_IDX_W +: QCN_IDX_W]);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      quad_clk <= '0;
    end else begin
      quad_clk <= next_quad_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge clock nets, left and right banks
  logic [QCN_EDGE_NETS-1:0] next_edge;

  always_comb begin
    for (int e = 0; e < QCN_EDGE_NETS; e++) begin
      case (edge_sel[e*QCN_EDGE_SEL_W +: QCN_EDGE_SEL_W])
        QCN_EDGE_PIN:     next_edge[e] = edge_pin[e];
        QCN_EDGE_DELAY90: next_edge[e] = delay_line_output[e];
        QCN_EDGE_SYNTH_P: next_edge[e] = synth_primary_output[e];
        QCN_EDGE_SYNTH_S: next_edge[e] = synth_secondary_output[e];
        QCN_EDGE_BRIDGE:  next_edge[e] = edge_clock_bridge[e];
        QCN_EDGE_INT:     next_edge[e] = edge_internal[e];
        default:          next_edge[e] = QCN_RST_LEVEL;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      edge_clock_net <= '0;
    end else begin
      edge_clock_net <= next_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  logic [QCN_IDX_W-1:0]      lane0_sel;
  logic [QCN_EDGE_SEL_W-1:0] edge0_sel;
  assign lane0_sel = center_sel[QCN_IDX_W-1:0];
  assign edge0_sel = edge_sel[QCN_EDGE_SEL_W-1:0];

  sequence s_old_high_done;
    sel_glitchless[0] && sel_state[0] == SEL_RUN && sel_choose[0] != sel_cur[0]
      && !sel_in_old[0];
  endsequence

  sequence s_hold_low;
    !sel_clk[0];
  endsequence

  a_gate_hold_low: assert property (!gate_on[0] |=> !gated[0])
    else $error("disabled gate let a pulse through");
  a_gate_no_runt: assert property ($fell(gated[0]) |-> !$past(mid_out[0]))
    else $error("gated clock fell while source high");
  a_gate_low_change: assert property ($changed(gate_on[0]) |-> !$past(mid_out[0]))
    else $error("gate moved during high phase");
  a_gate_rise_src: assert property ($rose(gated[0]) |-> $past(mid_out[0], 1))
    else $error("gated clock rose without source");
  a_center_lane_route: assert property (1'b1 |=> quad_clk[0] ==
      $past(pick_bit(center_pool, lane0_sel)))
    else $error("center lane output wrong");
  a_sel_plain_mux: assert property (!sel_glitchless[0] |=> sel_clk[0] == $past(sel_in_new[0])
      && sel_cur[0] == $past(sel_choose[0]))
    else $error("plain selector did not follow select");
  a_sel_switch_seq: assert property (s_old_high_done |=> s_hold_low)
    else $error("selector output not held low on switch");
  a_sel_cur_change: assert property (sel_glitchless[0] && $changed(sel_cur[0])
      && $past(sel_glitchless[0]) |-> $past(sel_state[0] == SEL_HOLD) && !$past(sel_in_new[0]))
    else $error("glitch-free selector switched outside low phase");
  a_edge_net_route: assert property (edge0_sel == QCN_EDGE_DELAY90 |=>
      edge_clock_net[0] == $past(delay_line_output[0]))
    else $error("edge net did not follow delay line");

  ////////////////////////////////////////////////////////////////////////////
  // Further taps: last lane and the right-most edge net
  logic [QCN_IDX_W-1:0]      lane63_sel;
  logic [QCN_EDGE_SEL_W-1:0] edge7_sel;
  assign lane63_sel = center_sel[(QCN_QUAD_CLOCKS-1)*QCN_IDX_W +: QCN_IDX_W];
  assign edge7_sel  = edge_sel[(QCN_EDGE_NETS-1)*QCN_EDGE_SEL_W +: QCN_EDGE_SEL_W];

  sequence s_sel_settled;
    sel_glitchless[0] && sel_state[0] == SEL_RUN && sel_choose[0] == sel_cur[0];
  endsequence

  sequence s_sel_holding;
    sel_glitchless[0] && sel_state[0] == SEL_HOLD;
  endsequence

  // Gate path: open gate passes a high phase one cycle later, enable only via second flop
  a_gate_pass_high: assert property (gate_on[0] && mid_out[0] |=> gated[0])
    else $error("open gate cut a high phase");
  a_gate_takes_sync: assert property ($changed(gate_on[0]) |->
      gate_on[0] == $past(en_sync[0]))
    else $error("gate took a value other than the synchronised enable");
  a_sync_second_flop: assert property (1'b1 |=>
      en_sync[0] == $past(en_meta[0]))
    else $error("enable synchroniser skipped a stage");

  // Selector path
  a_sel_hold_low: assert property (s_sel_holding |=> !sel_clk[0])
    else $error("selector output moved while holding");
  a_sel_run_follow: assert property (s_sel_settled |=>
      sel_clk[0] == $past(sel_in_old[0]))
    else $error("settled selector did not pass its input");
  a_sel1_plain: assert property (!sel_glitchless[1] |=>
      sel_clk[1] == $past(sel_in_new[1]))
    else $error("second selector did not follow select");

  // Center switch: far end of the lane range
  a_quad_last_route: assert property (1'b1 |=>
      quad_clk[QCN_QUAD_CLOCKS-1] == $past(pick_bit(center_pool, lane63_sel)))
    else $error("last quadrant lane output wrong");

  // Edge nets: pin source, unused codes, right side
  a_edge_pin_route: assert property (edge0_sel == QCN_EDGE_PIN |=>
      edge_clock_net[0] == $past(edge_pin[0]))
    else $error("edge net did not follow pin");
  a_edge_unused_low: assert property (edge0_sel > QCN_EDGE_INT |=>
      !edge_clock_net[0])
    else $error("unused edge code did not give low");
  a_edge_right_route: assert property (edge7_sel == QCN_EDGE_INT |=>
      edge_clock_net[QCN_EDGE_NETS-1] == $past(edge_internal[QCN_EDGE_NETS-1]))
    else $error("right edge net did not follow internal node");

endmodule

// ### bench/qcn_fabric_model.sv
// Fabric-side model: free-running sampled clock sources and the fabric clock.
// Assumes the bench clock; outputs move 1 ns after each rising edge.
`timescale 1ns/1ns

module qcn_fabric_model
  import qcn_pkg::*;
(
  // System
  input  wire logic                   clock,
  // Sources
  output logic      [QCN_SOURCES-1:0] clk_src,
  output logic                        fabric_clk
);
  logic [7:0] cnt = 8'h00;

  // Never stopped, so a glitch-free selector fed from these sources sees both inputs run
  always @(posedge clock) cnt <= #1 cnt + 8'h01;

  // Period 8, high 4, phase set by index so neighbours differ
  always_comb begin
    for (int i = 0; i < QCN_SOURCES; i++) begin
      clk_src[i] = 3'(cnt[2:0] + 3'(i)) > 3'h3;
    end
    fabric_clk = ~cnt[2];
  end
endmodule

// ### bench/qcn_clock_network_tb.sv
// Testbench for the quadrant clock network control block.
// Assumes the fabric model makes the primary sources and fabric clock, edge sources are fixed patterns; checks run on falling edges.
`timescale 1ns/1ns

module qcn_clock_network_tb
  import qcn_pkg::*;
;
  logic         clock = 1'b0;
  logic         srst = 1'b1;
  logic [63:0]  clk_src, gate_en, src_d1, src_d2, quad_clk, gate_on;
  logic         fabric_clk, fab_d1, fab_d2;
  logic [27:0]  sel_cand;
  logic [1:0]   sel_choose, sel_glitchless, sel_clk;
  logic [447:0] center_sel;
  logic [23:0]  edge_sel;
  logic [7:0]   edge_clock_net;
  logic [7:0]   esrc [8] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0, 8'h99, 8'h66, 8'h00, 8'h00};
  int           err_count, comparisons, cycles, run_q, run_s;
  bit           mon_gate, mon_sel;

  always #20 clock = ~clock;

  qcn_fabric_model FAB (.clock(clock), .clk_src(clk_src), .fabric_clk(fabric_clk));

  qcn_clock_network DUT (
    .clock(clock), .srst(srst), .clk_src(clk_src), .fabric_clk(fabric_clk),
    .gate_en(gate_en), .sel_cand(sel_cand), .sel_choose(sel_choose),
    .sel_glitchless(sel_glitchless), .center_sel(center_sel),
    .edge_pin(esrc[0]), .delay_line_output(esrc[1]), .synth_primary_output(esrc[2]),
    .synth_secondary_output(esrc[3]), .edge_clock_bridge(esrc[4]),
    .edge_internal(esrc[5]), .edge_sel(edge_sel), .quad_clk(quad_clk),
    .sel_clk(sel_clk), .gate_on(gate_on), .edge_clock_net(edge_clock_net));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    src_d1 <= clk_src;
    src_d2 <= src_d1;
    fab_d1 <= fabric_clk;
    fab_d2 <= fab_d1;
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  // Every high pulse must be whole: a runt shows as a short run
  always @(negedge clock) begin
    if (quad_clk[0] === 1'b1) run_q++;
    else begin
      if (mon_gate && run_q != 0) check(64'(run_q), 64'h4, "gate pulse");
      run_q = 0;
    end
    if (sel_clk[0] === 1'b1) run_s++;
    else begin
      if (mon_sel && run_s != 0) check(64'(run_s), 64'h4, "selector pulse");
      run_s = 0;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic set_lanes(input int off);
    for (int q = 0; q < QCN_QUAD_CLOCKS; q++) center_sel[q*7 +: 7] = 7'((q + off) % 64);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_route(input int off);
    logic [63:0] e;
    set_lanes(off);
    cyc(12);
    repeat (8) begin
      @(negedge clock);
      for (int q = 0; q < 64; q++) e[q] = src_d2[(q + off) % 64];
      check(quad_clk, e, "lane routing");
      check(gate_on, {64{1'b1}}, "gates open");
    end
  endtask

  task automatic t_gate();
    set_lanes(0);
    cyc(12);
    mon_gate = 1'b1;
    for (int k = 3; k < 8; k++) begin
      gate_en[0] = 1'b0;
      cyc(10);
      @(negedge clock);
      check({gate_on[0], quad_clk[0]}, 64'h0, "gate closed");
      cyc(k);
      gate_en[0] = 1'b1;
      cyc(k + 9);
    end
    mon_gate = 1'b0;
  endtask

  task automatic t_sel_plain();
    sel_cand = {7'h46, 7'h41, 7'h40, 7'h05};
    center_sel[6:0] = 7'h40;
    center_sel[16*7 +: 7] = 7'h41;
    center_sel[48*7 +: 7] = 7'h40;
    for (int c = 0; c < 2; c++) begin
      sel_choose = 2'(c);
      cyc(4);
      repeat (8) begin
        @(negedge clock);
        check(sel_clk, {1'b0, c ? fab_d1 : src_d1[5]}, "plain select");
        check(quad_clk[48], c ? fab_d2 : src_d2[5], "selector to quad");
        check({quad_clk[16], quad_clk[0]}, {1'b0, c ? fab_d2 : src_d2[5]}, "center in");
      end
    end
  endtask

  task automatic t_sel_glitchless();
    sel_cand = {7'h46, 7'h41, 7'h03, 7'h00};
    sel_glitchless = 2'h3;
    cyc(10);
    mon_sel = 1'b1;
    for (int k = 0; k < 4; k++) begin
      sel_choose[0] = ~sel_choose[0];
      cyc(24 + k);
      @(negedge clock);
      check(sel_clk[0], sel_choose[0] ? src_d1[3] : src_d1[0], "glitch-free select");
    end
    mon_sel = 1'b0;
  endtask

  task automatic t_edge();
    for (int c = 0; c < 8; c++) begin
      edge_sel = {8{3'(c)}};
      cyc(3);
      @(negedge clock);
      check(edge_clock_net, esrc[c], "edge source");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    gate_en = '1;
    sel_cand = '0;
    sel_choose = 2'h0;
    sel_glitchless = 2'h0;
    center_sel = '0;
    edge_sel = '0;
    cyc(9);
    @(negedge clock);
    check(quad_clk, 64'h0, "outputs in reset");
    check(gate_on, 64'h0, "outputs in reset");
    check(64'({sel_clk, edge_clock_net}), 64'h0, "outputs in reset");
    cyc(1);
    srst = 1'b0;
    t_route(0);
    t_route(37);
    t_gate();
    t_sel_plain();
    t_sel_glitchless();
    t_edge();
    results();
  end
endmodule
